//--- hw/tmp_pkg.sv
// Package of constants and carriers for the temperature alarm and index port block.
package tmp_pkg;
  localparam logic [2:0] PORT_INDEX = 3'h5;
  localparam logic [2:0] PORT_DATA = 3'h6;
  localparam logic [6:0] IDX_TEMP_ONE = 7'h27;
  localparam logic [6:0] IDX_TEMP_ONE_AI = 7'h67;
  localparam logic [6:0] IDX_CONFIG = 7'h40;
  localparam logic [6:0] IDX_STAT_FIRST = 7'h41;
  localparam logic [6:0] IDX_STAT_SECOND = 7'h42;
  localparam logic [6:0] IDX_MGMT_MASK_FIRST = 7'h43;
  localparam logic [6:0] IDX_MGMT_MASK_SECOND = 7'h44;
  localparam logic [6:0] IDX_NMI_MASK_FIRST = 7'h45;
  localparam logic [6:0] IDX_NMI_MASK_SECOND = 7'h46;
  localparam logic [6:0] IDX_VID_FAN = 7'h47;
  localparam logic [6:0] IDX_SER_ADDR = 7'h48;
  localparam logic [6:0] IDX_BANK_TMODE = 7'h4C;
  localparam logic [6:0] IDX_BANK_SEL = 7'h4E;
  localparam logic [6:0] IDX_REM_MSB = 7'h50;
  localparam logic [6:0] IDX_REM_LSB = 7'h51;
  localparam logic [6:0] IDX_REM_CFG = 7'h52;
  localparam logic [6:0] IDX_REM_HYST = 7'h53;
  localparam logic [6:0] IDX_REM_OVER = 7'h55;
  localparam logic [6:0] IDX_HYST_ONE = 7'h3A;
  localparam logic [6:0] IDX_OVER_ONE = 7'h39;
  localparam logic [6:0] IDX_SCRATCH_LAST = 7'h1F;
  localparam logic [6:0] IDX_VALUE_LAST = 7'h7F;
  localparam logic [6:0] IDX_VALUE_AI_FIRST = 7'h60;
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_NMI_SECOND = 8'h20;
  localparam logic [7:0] RST_SER_ADDR = 8'h2D;
  localparam logic [3:0] RST_FAN_DIV = 4'h5;
  localparam logic [7:0] HYST_COMPARATOR = 8'h7F;
  localparam int BIT_BUSY = 7;
  localparam int BIT_CFG_IRQ_EN = 1;
  localparam int BIT_CFG_RESTORE = 7;
  localparam int BIT_STAT_ONE = 4;
  localparam int BIT_STAT_TWO = 5;
  localparam int BIT_STAT_THREE = 5;
  localparam int BIT_TMODE = 6;
  localparam int BIT_OVT_MODE = 1;
  localparam int BIT_REM_LSB = 7;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] port;
    logic [7:0] wdata;
  } tmp_host_req_s;
  typedef struct packed {
    logic done;
    logic [7:0] temp_one;
    logic [8:0] temp_two;
    logic [8:0] temp_three;
  } tmp_conv_s;
endpackage : tmp_pkg

//--- hw/tmp_index_next.sv
// Next index pointer after a data-port access.
`timescale 1ns/1ps
`default_nettype none
module tmp_index_next
  import tmp_pkg::*;
(
  // Current pointer.
  input wire logic [6:0] cur_i,
  // Pointer after the access.
  output logic [6:0] nxt_o
);
  always_comb begin
    if (cur_i == IDX_STAT_FIRST || cur_i == IDX_MGMT_MASK_FIRST ||
        cur_i == IDX_NMI_MASK_FIRST) begin
      nxt_o = cur_i + 7'h01;
    end else if (cur_i < IDX_SCRATCH_LAST) begin
      nxt_o = cur_i + 7'h01;
    end else if (cur_i >= IDX_VALUE_AI_FIRST && cur_i < IDX_VALUE_LAST) begin
      nxt_o = cur_i + 7'h01;
    end else begin
      nxt_o = cur_i;
    end
  end
endmodule : tmp_index_next
`default_nettype wire

//--- hw/tmp_zone.sv
// Alarm state for one temperature zone: interrupt event and over-temperature output.
`timescale 1ns/1ps
`default_nettype none
module tmp_zone
  import tmp_pkg::*;
#(
  parameter int W = 9
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Conversion result and limits.
  input wire logic done_i,
  input wire logic signed [W-1:0] temp_i,
  input wire logic signed [W-1:0] over_i,
  input wire logic signed [W-1:0] hyst_i,
  // Modes: comparator interrupt, comparator for over-temperature output, zone one.
  input wire logic irq_cmp_i,
  input wire logic ovt_cmp_i,
  input wire logic zone_one_i,
  // Clears.
  input wire logic stat_clr_i,
  input wire logic ovt_clr_i,
  // Results.
  output logic event_o,
  output logic ovt_o
);
  logic armed_hi;
  logic ovt_hi;
  logic above_over;
  logic below_hyst;
  logic event_pend;
  assign above_over = temp_i > over_i;
  assign below_hyst = temp_i < hyst_i;
  assign event_o = event_pend;
  // Evaluation only at conversion end; a new event wins over a read clear.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      event_pend <= 1'b0;
      armed_hi <= 1'b1;
    end else if (done_i) begin
      if (irq_cmp_i) begin
        if (above_over && (zone_one_i || !event_pend)) begin
          event_pend <= 1'b1;
        end else if (!zone_one_i && !below_hyst && !event_pend) begin
          event_pend <= 1'b1;
        end else if (stat_clr_i) begin
          event_pend <= 1'b0;
        end
      end else if (armed_hi && above_over) begin
        event_pend <= 1'b1;
        armed_hi <= 1'b0;
      end else if (!armed_hi && below_hyst && !event_pend) begin
        event_pend <= 1'b1;
        armed_hi <= 1'b1;
      end else if (stat_clr_i) begin
        event_pend <= 1'b0;
      end
    end else if (stat_clr_i) begin
      event_pend <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ovt_o <= 1'b0;
      ovt_hi <= 1'b1;
    end else if (ovt_cmp_i) begin
      if (done_i && above_over) begin
        ovt_o <= 1'b1;
      end else if (done_i && below_hyst) begin
        ovt_o <= 1'b0;
      end
    end else if (done_i && ovt_hi && above_over) begin
      ovt_o <= 1'b1;
      ovt_hi <= 1'b0;
    end else if (done_i && !ovt_hi && below_hyst && !ovt_o) begin
      ovt_o <= 1'b1;
      ovt_hi <= 1'b1;
    end else if (ovt_clr_i) begin
      ovt_o <= 1'b0;
    end
  end
  a_eval_done: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !done_i && !stat_clr_i |=> $stable(event_pend))
    else $error("zone event moved between conversions");
  a_ovt_eval: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !done_i && !ovt_clr_i |=> $stable(ovt_o))
    else $error("zone overtemp moved between conversions");
endmodule : tmp_zone
`default_nettype wire

//--- hw/tmp_alarm_port.sv
// Temperature alarm logic with the indexed host access port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Sensor one reads as 8-bit degrees.
// - Sensor one reading at index 27h.
// - Sensors two, three: 9-bit at 50h/51h bit7.
// - Hysteresis 127 selects sensor one comparator mode.
// - Comparator: re-raise per conversion above limit.
// - Two-times: over, then under hysteresis.
// - Bit 6 of 4Ch picks remote mode.
// - Remote comparator repeats above hysteresis.
// - Bit 1 of 52h picks output mode.
// - Comparator output holds until below hysteresis.
// - Interrupt output latches until remote read.
// - Index port: 7-bit pointer, busy bit.
// - Busy sets on index write or serial.
// - Busy clears on data access or serial end.
// - Index 41h advances to 42h.
// - Index 43h advances to 44h.
// - Index 45h advances to 46h.
// - Scratch RAM increments, stops at 1Fh.
// - Value window increments, stops at 7Fh.
// - Status bits 4/5 first, bit 5 second.
// - Interrupt output only with configuration bit 1.
module tmp_alarm_port
  import tmp_pkg::*;
#(
  parameter int RAM_DEPTH = 32
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Host port access, one-cycle strobes.
  input wire tmp_host_req_s host_i,
  output logic [7:0] host_rdata_o,
  // Serial bus transaction in progress.
  input wire logic serial_busy_i,
  // Conversion results and voltage ID inputs.
  input wire tmp_conv_s conv_i,
  input wire logic [3:0] voltage_id_inputs_i,
  // Alarm outputs, active low.
  output logic mgmt_interrupt_out_n_o,
  output logic overtemp_alert_out_n_o
);
  logic [6:0] index_pointer_bits;
  logic busy_host;
  logic [7:0] cfg;
  logic [7:0] stat_first;
  logic [7:0] stat_second;
  logic [7:0] mask_first;
  logic [7:0] mask_second;
  logic [7:0] nmi_first;
  logic [7:0] nmi_second;
  logic [3:0] fan_div;
  logic [6:0] ser_addr;
  logic [7:0] bank;
  logic [7:0] hyst_one;
  logic [7:0] over_one;
  logic [7:0] tmode;
  logic [7:0] rem_cfg [2];
  logic [8:0] rem_hyst [2];
  logic [8:0] rem_over [2];
  logic [7:0] scratch [RAM_DEPTH];
  logic [6:0] next_index;
  logic data_acc;
  logic data_wr;
  logic data_rd;
  logic index_wr;
  logic stat_read;
  logic rem_read;
  logic restore;
  logic [2:0] zone_event;
  logic [2:0] zone_ovt;
  logic [2:0] event_q;
  logic [7:0] next_rdata;
  logic rem_bank;
  logic in_rem;
  logic [7:0] rem_sel;

  // One decode for the data and index strobes; the read data mux and the busy and sensor one assertions compare the port directly.
  function automatic logic port_hit(input logic strobe, input logic [2:0] port,
                                    input logic [2:0] want);
    return strobe && port == want;
  endfunction : port_hit

  assign data_rd = port_hit(host_i.rd, host_i.port, PORT_DATA);
  assign data_wr = port_hit(host_i.wr, host_i.port, PORT_DATA);
  assign index_wr = port_hit(host_i.wr, host_i.port, PORT_INDEX);
  assign data_acc = data_rd || data_wr;
  assign stat_read = data_rd &&
                     (index_pointer_bits == IDX_STAT_FIRST ||
                      index_pointer_bits == IDX_STAT_SECOND);
  assign in_rem = bank[2:0] == 3'h1 || bank[2:0] == 3'h2;
  assign rem_bank = bank[2:0] == 3'h2;
  assign rem_read = data_rd && in_rem &&
                    index_pointer_bits >= IDX_REM_MSB && index_pointer_bits <= IDX_REM_OVER;
  assign restore = data_wr && index_pointer_bits == IDX_CONFIG && host_i.wdata[BIT_CFG_RESTORE];

  tmp_index_next u_next (
    .cur_i(index_pointer_bits),
    .nxt_o(next_index)
  );

  // Index pointer and host busy flag.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      index_pointer_bits <= RST_INDEX[6:0];
      busy_host <= RST_INDEX[BIT_BUSY];
    end else if (index_wr) begin
      index_pointer_bits <= host_i.wdata[6:0];
      busy_host <= 1'b1;
    end else if (data_acc) begin
      index_pointer_bits <= next_index;
      busy_host <= 1'b0;
    end
  end

  // Registers written through the data port.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || restore) begin
      cfg <= RST_CONFIG;
      mask_first <= RST_ZERO;
      mask_second <= RST_ZERO;
      nmi_first <= RST_ZERO;
      nmi_second <= RST_NMI_SECOND;
      fan_div <= RST_FAN_DIV;
      bank <= RST_ZERO;
      hyst_one <= HYST_COMPARATOR;
      over_one <= HYST_COMPARATOR;
      tmode <= RST_ZERO;
      for (int b = 0; b < 2; b++) begin
        rem_cfg[b] <= RST_ZERO;
        rem_hyst[b] <= {HYST_COMPARATOR, 1'b0};
        rem_over[b] <= {HYST_COMPARATOR, 1'b0};
      end
    end else if (data_wr) begin
      case (index_pointer_bits)
        IDX_CONFIG: cfg <= host_i.wdata;
        IDX_MGMT_MASK_FIRST: mask_first <= host_i.wdata;
        IDX_MGMT_MASK_SECOND: mask_second <= {2'b00, host_i.wdata[5:0]};
        IDX_NMI_MASK_FIRST: nmi_first <= host_i.wdata;
        IDX_NMI_MASK_SECOND: nmi_second <= host_i.wdata;
        IDX_VID_FAN: fan_div <= host_i.wdata[7:4];
        IDX_BANK_SEL: bank <= host_i.wdata;
        IDX_HYST_ONE: hyst_one <= host_i.wdata;
        IDX_OVER_ONE: over_one <= host_i.wdata;
        IDX_BANK_TMODE: tmode <= host_i.wdata;
        IDX_REM_CFG: if (in_rem) rem_cfg[rem_bank] <= host_i.wdata;
        IDX_REM_HYST: if (in_rem) rem_hyst[rem_bank] <= {host_i.wdata, 1'b0};
        IDX_REM_OVER: if (in_rem) rem_over[rem_bank] <= {host_i.wdata, 1'b0};
        default: ;
      endcase
    end
  end

  // The serial address survives the restore bit on purpose.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ser_addr <= RST_SER_ADDR[6:0];
    end else if (data_wr && index_pointer_bits == IDX_SER_ADDR) begin
      ser_addr <= host_i.wdata[6:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (data_wr && index_pointer_bits <= IDX_SCRATCH_LAST) begin
      scratch[index_pointer_bits[4:0]] <= host_i.wdata;
    end
  end

  // Zone one is comparator whenever its hysteresis reads 127 degrees.
  tmp_zone #(.W(8)) u_zone_one (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .done_i(conv_i.done),
    .temp_i(conv_i.temp_one),
    .over_i(over_one),
    .hyst_i(hyst_one),
    .irq_cmp_i(hyst_one == HYST_COMPARATOR),
    .ovt_cmp_i(1'b1),
    .zone_one_i(1'b1),
    .stat_clr_i(stat_read),
    .ovt_clr_i(1'b0),
    .event_o(zone_event[0]),
    .ovt_o()
  );

  for (genvar z = 0; z < 2; z++) begin : g_rem
    tmp_zone #(.W(9)) u_zone (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .done_i(conv_i.done),
      .temp_i(z == 0 ? conv_i.temp_two : conv_i.temp_three),
      .over_i(rem_over[z]),
      .hyst_i(rem_hyst[z]),
      .irq_cmp_i(!tmode[BIT_TMODE]),
      .ovt_cmp_i(!rem_cfg[z][BIT_OVT_MODE]),
      .zone_one_i(1'b0),
      .stat_clr_i(stat_read),
      .ovt_clr_i(rem_read),
      .event_o(zone_event[z+1]),
      .ovt_o(zone_ovt[z+1])
    );
  end
  assign zone_ovt[0] = 1'b0;

  // Status flags latch the rising edge of a zone event, which shows one cycle after the
  // conversion; pairing the zone flag with done would see only the older event.
  // A new event wins over the read clear.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      stat_first <= RST_ZERO;
      stat_second <= RST_ZERO;
      event_q <= 3'h0;
    end else begin
      event_q <= zone_event;
      if (data_rd && index_pointer_bits == IDX_STAT_FIRST) begin
        stat_first <= RST_ZERO;
      end
      if (data_rd && index_pointer_bits == IDX_STAT_SECOND) begin
        stat_second <= RST_ZERO;
      end
      if (zone_event[0] && !event_q[0]) stat_first[BIT_STAT_ONE] <= 1'b1;
      if (zone_event[1] && !event_q[1]) stat_first[BIT_STAT_TWO] <= 1'b1;
      if (zone_event[2] && !event_q[2]) stat_second[BIT_STAT_THREE] <= 1'b1;
    end
  end

  always_comb begin
    rem_sel = RST_ZERO;
    case (index_pointer_bits)
      IDX_REM_MSB: rem_sel = rem_bank ? conv_i.temp_three[8:1] : conv_i.temp_two[8:1];
      IDX_REM_LSB: rem_sel = {rem_bank ? conv_i.temp_three[0] : conv_i.temp_two[0], 7'h00};
      IDX_REM_CFG: rem_sel = rem_cfg[rem_bank];
      IDX_REM_HYST: rem_sel = rem_hyst[rem_bank][8:1];
      IDX_REM_OVER: rem_sel = rem_over[rem_bank][8:1];
      default: rem_sel = RST_ZERO;
    endcase
  end

  always_comb begin
    next_rdata = RST_ZERO;
    if (host_i.port == PORT_INDEX) begin
      next_rdata = {busy_host || serial_busy_i, index_pointer_bits};
    end else if (index_pointer_bits <= IDX_SCRATCH_LAST) begin
      next_rdata = scratch[index_pointer_bits[4:0]];
    end else if (in_rem && index_pointer_bits >= IDX_REM_MSB) begin
      next_rdata = rem_sel;
    end else begin
      case (index_pointer_bits)
        IDX_TEMP_ONE, IDX_TEMP_ONE_AI: next_rdata = conv_i.temp_one;
        IDX_CONFIG: next_rdata = cfg;
        IDX_STAT_FIRST: next_rdata = stat_first;
        IDX_STAT_SECOND: next_rdata = stat_second;
        IDX_MGMT_MASK_FIRST: next_rdata = mask_first;
        IDX_MGMT_MASK_SECOND: next_rdata = mask_second;
        IDX_NMI_MASK_FIRST: next_rdata = nmi_first;
        IDX_NMI_MASK_SECOND: next_rdata = nmi_second;
        IDX_VID_FAN: next_rdata = {fan_div, voltage_id_inputs_i};
        IDX_SER_ADDR: next_rdata = {1'b0, ser_addr};
        IDX_BANK_SEL: next_rdata = bank;
        IDX_HYST_ONE: next_rdata = hyst_one;
        IDX_OVER_ONE: next_rdata = over_one;
        IDX_BANK_TMODE: next_rdata = tmode;
        default: next_rdata = RST_ZERO;
      endcase
    end
  end

  // Read data is registered so the host samples it one cycle after the strobe.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      host_rdata_o <= RST_ZERO;
    end else if (host_i.rd) begin
      host_rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mgmt_interrupt_out_n_o <= 1'b1;
      overtemp_alert_out_n_o <= 1'b1;
    end else begin
      mgmt_interrupt_out_n_o <= !(cfg[BIT_CFG_IRQ_EN] &&
        ((|(stat_first & ~mask_first)) || (|(stat_second & ~mask_second))));
      overtemp_alert_out_n_o <= !(|zone_ovt);
    end
  end

  a_busy_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    host_i.wr && host_i.port == PORT_INDEX |=> busy_host)
    else $error("busy not set by index write");
  a_busy_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && !(host_i.wr && host_i.port == PORT_INDEX) |=> !busy_host)
    else $error("busy not cleared by data access");
  a_ptr_stat: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits == IDX_STAT_FIRST |=> index_pointer_bits == IDX_STAT_SECOND)
    else $error("status pointer did not advance");
  a_ptr_mask: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits == IDX_MGMT_MASK_FIRST |=> index_pointer_bits == IDX_MGMT_MASK_SECOND)
    else $error("mask pointer did not advance");
  a_ptr_nmi: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits == IDX_NMI_MASK_FIRST |=> index_pointer_bits == IDX_NMI_MASK_SECOND)
    else $error("nmi pointer did not advance");
  a_scratch_stop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits == IDX_SCRATCH_LAST |=> $stable(index_pointer_bits))
    else $error("scratch pointer passed its end");
  a_value_stop: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits == IDX_VALUE_LAST |=> index_pointer_bits == IDX_VALUE_LAST)
    else $error("value pointer wrapped");
  a_irq_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !cfg[BIT_CFG_IRQ_EN] |=> mgmt_interrupt_out_n_o)
    else $error("interrupt driven while disabled");
  a_temp_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    host_i.rd && host_i.port == PORT_DATA && index_pointer_bits == IDX_TEMP_ONE
    |=> host_rdata_o == $past(conv_i.temp_one))
    else $error("sensor one reading wrong");
  a_ptr_load: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    index_wr |=> index_pointer_bits == $past(host_i.wdata[6:0]))
    else $error("pointer not loaded by index write");
  a_busy_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    host_i.rd && host_i.port == PORT_INDEX |=> host_rdata_o[BIT_BUSY] == $past(busy_host || serial_busy_i))
    else $error("busy bit reads wrong");
  a_ptr_scratch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_acc && index_pointer_bits < IDX_SCRATCH_LAST |=> index_pointer_bits == $past(index_pointer_bits) + 7'h01)
    else $error("scratch pointer did not step");
  a_rem_lsb: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_rd && in_rem && index_pointer_bits == IDX_REM_LSB |=> host_rdata_o[6:0] == 7'h00)
    else $error("remote low byte has stray bits");
  a_stat_one: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    zone_event[0] && !event_q[0] |=> stat_first[BIT_STAT_ONE])
    else $error("sensor one event not flagged");
  a_stat_two: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    zone_event[1] && !event_q[1] |=> stat_first[BIT_STAT_TWO])
    else $error("sensor two event not flagged");
  a_stat_three: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    zone_event[2] && !event_q[2] |=> stat_second[BIT_STAT_THREE])
    else $error("sensor three event not flagged");
  a_ovt_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    |zone_ovt |=> !overtemp_alert_out_n_o)
    else $error("overtemp output not driven");
endmodule : tmp_alarm_port
`default_nettype wire

//--- sim/tmp_host_model.sv
// Host bus master model driving the indexed access port and the serial busy level.
`timescale 1ns/1ps
`default_nettype none
module tmp_host_model
  import tmp_pkg::*;
(
  // Clock.
  input wire logic ref_clk_i,
  // Read data returned by the port.
  input wire logic [7:0] host_rdata_i,
  // Requests towards the device.
  output var tmp_host_req_s host_o,
  output var logic serial_busy_o
);
  initial begin
    host_o = '0;
    serial_busy_o = 1'b0;
  end
  // An idle cycle follows each strobe, so two accesses never merge into one long strobe.
  task automatic access(input logic wr, input logic [2:0] port, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    @(posedge ref_clk_i);
    host_o <= '{wr: wr, rd: !wr, port: port, wdata: wdata};
    @(posedge ref_clk_i);
    host_o <= '0;
    #1;
    rdata = host_rdata_i;
  endtask : access
  // Serial traffic is only raised or dropped while no host access is in flight.
  task automatic serial(input logic busy);
    @(posedge ref_clk_i);
    serial_busy_o <= busy;
  endtask : serial
endmodule : tmp_host_model
`default_nettype wire

//--- sim/tmp_alarm_port_tb_top.sv
// Testbench for the temperature alarm and index port block.
`timescale 1ns/1ps
`default_nettype none
module tmp_alarm_port_tb_top
  import tmp_pkg::*;
;
  logic ref_clk_i;
  logic sys_rst_i;
  tmp_host_req_s host;
  logic [7:0] rdata;
  logic serial_busy;
  tmp_conv_s conv;
  logic [3:0] voltage_id_inputs;
  logic mgmt_n;
  logic ovt_n;
  int err_count;
  int total_checks;
  logic [7:0] v;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [6:0] ridx [9] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45, 7'h46, 7'h47, 7'h48};
  logic [7:0] rexp [9] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h5A, 8'h2D};
  logic [7:0] aidx [8] = '{8'h41, 8'h43, 8'h45, 8'h1E, 8'h7E, 8'h1F, 8'h7F, 8'h60};
  logic [7:0] aexp [8] = '{8'h42, 8'h44, 8'h46, 8'h1F, 8'h7F, 8'h1F, 8'h7F, 8'h61};

  tmp_alarm_port tmp_alarm_port_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .host_i(host), .host_rdata_o(rdata), .serial_busy_i(serial_busy), .conv_i(conv),
    .voltage_id_inputs_i(voltage_id_inputs), .mgmt_interrupt_out_n_o(mgmt_n),
    .overtemp_alert_out_n_o(ovt_n));
  tmp_host_model tmp_host_model_inst (.ref_clk_i(ref_clk_i), .host_rdata_i(rdata),
    .host_o(host), .serial_busy_o(serial_busy));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] port, input logic [7:0] d);
    logic [7:0] unused;
    tmp_host_model_inst.access(1'b1, port, d, unused);
  endtask : wr
  task automatic rd(input logic [2:0] port, output logic [7:0] d);
    tmp_host_model_inst.access(1'b0, port, 8'h00, d);
  endtask : rd
  task automatic wreg(input logic [6:0] idx, input logic [7:0] d);
    wr(PORT_INDEX, {1'b0, idx});
    wr(PORT_DATA, d);
  endtask : wreg
  task automatic rreg(input logic [6:0] idx, output logic [7:0] d);
    wr(PORT_INDEX, {1'b0, idx});
    rd(PORT_DATA, d);
  endtask : rreg
  // Both status registers in one pass, relying on the pointer stepping from 41h to 42h.
  task automatic stat();
    rreg(IDX_STAT_FIRST, s1);
    rd(PORT_DATA, s2);
  endtask : stat
  // Outputs lag the status change by a cycle, so settle a few edges before looking.
  task automatic convert(input logic [7:0] t1, input logic [8:0] t2, input logic [8:0] t3);
    @(posedge ref_clk_i);
    conv <= '{done: 1'b1, temp_one: t1, temp_two: t2, temp_three: t3};
    @(posedge ref_clk_i);
    conv.done <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : convert
  task automatic settle();
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : settle
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    wrap_up();
  end

  initial begin
    sys_rst_i = 1'b1;
    conv = '0;
    voltage_id_inputs = 4'hA;
    err_count = 0;
    total_checks = 0;
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(PORT_INDEX, v);
    chk("index port reset", RST_INDEX, v);
    for (int i = 0; i < 9; i++) begin
      rreg(ridx[i], v);
      chk("register reset", rexp[i], v);
    end
    wr(PORT_INDEX, 8'h41);
    rd(PORT_INDEX, v);
    chk("busy after index write", 8'hC1, v);
    for (int i = 0; i < 8; i++) begin
      wr(PORT_INDEX, aidx[i]);
      if (i % 2 == 1) wr(PORT_DATA, 8'h00);
      else rd(PORT_DATA, v);
      rd(PORT_INDEX, v);
      chk("pointer advance", aexp[i], v);
    end
    tmp_host_model_inst.serial(1'b1);
    rd(PORT_INDEX, v);
    chk("busy in serial", 8'hE1, v);
    tmp_host_model_inst.serial(1'b0);
    rd(PORT_INDEX, v);
    chk("busy after serial", 8'h61, v);
    convert(8'hC9, 9'h1FF, 9'h0FA);
    rreg(IDX_TEMP_ONE, v);
    chk("temp one", 8'hC9, v);
    wreg(IDX_BANK_SEL, 8'h01);
    rreg(IDX_REM_MSB, v);
    chk("temp two msb", 8'hFF, v);
    rreg(IDX_REM_LSB, v);
    chk("temp two lsb", 8'h01, {7'h00, v[7]});
    wreg(IDX_BANK_SEL, 8'h02);
    rreg(IDX_REM_MSB, v);
    chk("temp three msb", 8'h7D, v);
    rreg(IDX_REM_LSB, v);
    chk("temp three lsb", 8'h00, {7'h00, v[7]});
    wreg(IDX_CONFIG, 8'h01);
    wreg(IDX_OVER_ONE, 8'h32);
    convert(8'h40, 9'h000, 9'h000);
    chk("irq disabled", 8'h01, {7'h00, mgmt_n});
    stat();
    chk("sensor one event", 8'h10, s1);
    wreg(IDX_CONFIG, 8'h03);
    convert(8'h40, 9'h000, 9'h000);
    chk("irq enabled", 8'h00, {7'h00, mgmt_n});
    stat();
    chk("comparator repeat", 8'h10, s1);
    chk("irq cleared", 8'h01, {7'h00, mgmt_n});
    convert(8'h20, 9'h000, 9'h000);
    stat();
    chk("comparator below", 8'h00, s1);
    wreg(IDX_HYST_ONE, 8'h28);
    convert(8'h40, 9'h000, 9'h000);
    stat();
    chk("two times over", 8'h10, s1);
    convert(8'h30, 9'h000, 9'h000);
    stat();
    chk("two times between", 8'h00, s1);
    convert(8'h20, 9'h000, 9'h000);
    stat();
    chk("two times under", 8'h10, s1);
    wreg(IDX_BANK_SEL, 8'h01);
    wreg(IDX_REM_OVER, 8'h32);
    wreg(IDX_REM_HYST, 8'h28);
    convert(8'h20, {8'h40, 1'b0}, 9'h000);
    chk("ovt comparator over", 8'h00, {7'h00, ovt_n});
    stat();
    chk("sensor two event", 8'h20, s1);
    convert(8'h20, {8'h30, 1'b0}, 9'h000);
    chk("ovt comparator hold", 8'h00, {7'h00, ovt_n});
    stat();
    chk("remote comparator repeat", 8'h20, s1);
    convert(8'h20, {8'h20, 1'b0}, 9'h000);
    chk("ovt comparator release", 8'h01, {7'h00, ovt_n});
    stat();
    chk("remote comparator stop", 8'h00, s1);
    wreg(IDX_REM_CFG, 8'h02);
    wreg(IDX_BANK_SEL, 8'h02);
    wreg(IDX_REM_CFG, 8'h02);
    convert(8'h20, {8'h40, 1'b0}, 9'h000);
    convert(8'h20, {8'h30, 1'b0}, 9'h000);
    chk("ovt latched", 8'h00, {7'h00, ovt_n});
    rreg(IDX_REM_MSB, v);
    settle();
    chk("ovt reset by read", 8'h01, {7'h00, ovt_n});
    convert(8'h20, {8'h30, 1'b0}, 9'h000);
    chk("ovt stays off", 8'h01, {7'h00, ovt_n});
    convert(8'h20, {8'h20, 1'b0}, 9'h000);
    chk("ovt under hysteresis", 8'h00, {7'h00, ovt_n});
    rreg(IDX_REM_MSB, v);
    settle();
    chk("ovt second reset", 8'h01, {7'h00, ovt_n});
    wreg(IDX_REM_OVER, 8'h32);
    wreg(IDX_REM_HYST, 8'h28);
    wreg(IDX_BANK_TMODE, 8'h40);
    stat();
    convert(8'h20, {8'h20, 1'b0}, {8'h40, 1'b0});
    stat();
    chk("sensor three over", 8'h20, s2);
    convert(8'h20, {8'h20, 1'b0}, {8'h30, 1'b0});
    stat();
    chk("sensor three between", 8'h00, s2);
    convert(8'h20, {8'h20, 1'b0}, {8'h20, 1'b0});
    stat();
    chk("sensor three under", 8'h20, s2);
    wreg(IDX_MGMT_MASK_SECOND, 8'h20);
    convert(8'h20, {8'h20, 1'b0}, {8'h40, 1'b0});
    chk("irq masked", 8'h01, {7'h00, mgmt_n});
    stat();
    chk("masked status", 8'h20, s2);
    wrap_up();
  end
endmodule : tmp_alarm_port_tb_top
`default_nettype wire
